// ===== panel_pkg.sv
package panel_pkg;
   localparam int HIST_DEPTH = 10;
   localparam logic [3:0] HIST_PTR_RST = 4'h0;
   localparam logic [7:0] PARAM_SELECTOR = 8'h00;
   localparam logic [7:0] PARAM_SETUP_ONE = 8'h01;
   localparam logic [7:0] PARAM_SETUP_TWO = 8'h02;
   localparam logic [7:0] PARAM_JOG_SPEED = 8'h10;
   localparam logic [7:0] PARAM_NUM_MAX = 8'h1f;
   localparam logic [15:0] SETUP_ONE_RST = 16'h084c;
   localparam logic [15:0] SETUP_TWO_RST = 16'h0000;
   localparam logic [15:0] JOG_SPEED_RST = 16'h01f4;
   localparam logic [15:0] NV_MARK = 16'h5ac3;
   localparam logic [3:0] BIT_IDX_RST = 4'h0;
   localparam logic [7:0] CHK_JOG = 8'h00;
   localparam logic [7:0] CHK_AUTO_OFS = 8'h01;
   localparam logic [7:0] CHK_HIST_CLR = 8'h02;
   localparam logic [7:0] CHK_MAN_OFS = 8'h03;
   localparam logic [7:0] CHK_MOTOR = 8'h04;
   localparam logic [7:0] CHK_TUNE = 8'h05;
   localparam logic [1:0] SYM_BASEBLOCK = 2'h0;
   localparam logic [1:0] SYM_RUN = 2'h1;
   localparam logic [1:0] SYM_FWD_PROHIB = 2'h2;
   localparam logic [1:0] SYM_REV_PROHIB = 2'h3;

   typedef enum logic [1:0] {
      MODE_STATUS,
      MODE_SETTINGS,
      MODE_MONITOR,
      MODE_ALARM
   } panel_mode_t;

   typedef enum logic [2:0] {
      CHECK_NONE,
      CHECK_JOG,
      CHECK_AUTO_OFS,
      CHECK_MAN_OFS,
      CHECK_MOTOR,
      CHECK_TUNE
   } check_t;

   typedef struct packed {
      logic mode_set;
      logic data;
      logic up;
      logic down;
      logic left;
      logic right;
      logic servo;
      logic alarm_reset;
   } keys_t;

   typedef struct packed {
      logic alarm;
      logic fwd_prohib;
      logic rev_prohib;
      logic running;
   } drive_status_t;

   typedef struct packed {
      logic [4:0] blank;
      logic [4:0] bar_mode;
      logic [3:0][3:0] digits;
      logic [3:0] bit_digit;
      logic [15:0] bars;
      logic [7:0] value_lo;
   } display_t;
endpackage : panel_pkg

// ===== operator_panel_param_editor.sv
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// - Mode key cycles status, settings, monitor, alarm history modes.
// - Alarm history keeps at most ten entries.
// - Selector value 00 to 05 picks one of six check functions.
// - Auto-tuning runs the motor at half the jog speed.
// - Auto offset captures present speed and torque inputs as zero.
// - Check code 02 clears the alarm history count and view pointer; stored codes stay.
// - Check code 03 lets keys adjust only the speed command offset.
// - Stored setup words act only after the next power-up.
// - Setup edit shows 16 bits left, bit index on the rightmost digit.
// - A setup bar is lit for 1 and dark for 0.
// - Hand-held left and right keys move the selected bit index.
// - Hand-held up or down inverts the selected bit.
// - Hand-held mode or data key commits the setup word.
// - Panel-mounted up and down keys move the bit index.
// - Panel-mounted mode key inverts the selected bit while editing.
// - Panel-mounted: only the data key commits the setup word.
// - After storing, data key returns to parameter number display.
// - Mode key after storing goes from settings to monitor mode.
// - Data key toggles parameter number and parameter contents.
// - Up increments, down decrements parameter number or value.
// - During jog a dedicated key toggles servo on and off.
// - Status mode shows baseblock, run or prohibit symbol, or the newest alarm code.
module operator_panel_param_editor
   import panel_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic hand_held_in,
   input wire keys_t keys_in,
   input wire drive_status_t drive_status_in,
   input wire logic alarm_raise_in,
   input wire logic [7:0] alarm_code_in,
   input wire logic [15:0] speed_cmd_in,
   input wire logic [15:0] torque_cmd_in,
   output panel_mode_t mode_out,
   output check_t check_out,
   output logic servo_on_out,
   output logic [15:0] motor_speed_out,
   output logic [15:0] setup_one_active_out,
   output logic [15:0] setup_two_active_out,
   output logic [15:0] speed_offset_out,
   output logic [15:0] torque_offset_out,
   output logic nvm_write_out,
   output logic [7:0] nvm_addr_out,
   output logic [15:0] nvm_data_out,
   output logic alarm_reset_out,
   output logic [3:0] hist_count_out,
   output logic [7:0] hist_code_out,
   output logic show_data_out,
   output logic [7:0] param_num_out,
   output display_t display_out
);

   typedef struct packed {
      logic [1:0] sync0;
      logic [15:0] nv_mark;
      keys_t key0;
      keys_t key1;
      keys_t key_prev;
      panel_mode_t mode;
      check_t check;
      logic show_data;
      logic stored;
      logic [7:0] pnum;
      logic [7:0] selector;
      logic [15:0] edit_word;
      logic [3:0] bit_idx;
      logic [15:0] setup_one_nv;
      logic [15:0] setup_two_nv;
      logic [15:0] setup_one_act;
      logic [15:0] setup_two_act;
      logic [15:0] jog_speed;
      logic [15:0] spd_ofs;
      logic [15:0] trq_ofs;
      logic servo_on;
      logic nvm_write;
      logic [7:0] nvm_addr;
      logic [15:0] nvm_data;
      logic alarm_reset;
      logic [HIST_DEPTH-1:0][7:0] hist;
      logic [3:0] hist_cnt;
      logic [3:0] hist_view;
      logic [1:0] alarm_raise_sync;
      logic alarm_raise_prev;
   } state_t;

   state_t st_ff;
   state_t nxt_st;
   keys_t press;

   function automatic logic is_setup(input logic [7:0] num);
      is_setup = (num == PARAM_SETUP_ONE) || (num == PARAM_SETUP_TWO);
   endfunction : is_setup

   function automatic logic editing_setup(input state_t s);
      editing_setup = (s.mode == MODE_SETTINGS) && s.show_data && is_setup(s.pnum);
   endfunction : editing_setup

   function automatic logic [15:0] param_value(input state_t s, input logic [7:0] num);
      if (num == PARAM_SELECTOR) begin
         param_value = {8'h00, s.selector};
      end else if (num == PARAM_SETUP_ONE) begin
         param_value = s.setup_one_nv;
      end else if (num == PARAM_SETUP_TWO) begin
         param_value = s.setup_two_nv;
      end else if (num == PARAM_JOG_SPEED) begin
         param_value = s.jog_speed;
      end else begin
         param_value = 16'h0000;
      end
   endfunction : param_value

   // Keys come from a separate unit, so they pass two flip-flops first.
   assign press = st_ff.key1 & ~st_ff.key_prev;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.key0 = keys_in;
      nxt_st.key1 = st_ff.key0;
      nxt_st.key_prev = st_ff.key1;
      // The key map select is a pin as well, so it is synchronised like the keys.
      nxt_st.sync0 = {st_ff.sync0[0], hand_held_in};
      nxt_st.alarm_raise_sync = {st_ff.alarm_raise_sync[0], alarm_raise_in};
      nxt_st.alarm_raise_prev = st_ff.alarm_raise_sync[1];
      nxt_st.nvm_write = 1'b0;
      nxt_st.alarm_reset = press.alarm_reset;
      // A new alarm is stored newest first; the oldest falls off at ten.
      if (st_ff.alarm_raise_sync[1] && !st_ff.alarm_raise_prev) begin
         nxt_st.hist = {st_ff.hist[HIST_DEPTH-2:0], alarm_code_in};
         if (st_ff.hist_cnt < 4'(HIST_DEPTH)) begin
            nxt_st.hist_cnt = st_ff.hist_cnt + 4'h1;
         end
      end
      if (st_ff.check != CHECK_NONE) begin
         if (press.servo && st_ff.check == CHECK_JOG) begin
            nxt_st.servo_on = ~st_ff.servo_on;
         end
         if (st_ff.check == CHECK_MAN_OFS) begin
            if (press.up) begin
               nxt_st.spd_ofs = st_ff.spd_ofs + 16'h0001;
            end else if (press.down) begin
               nxt_st.spd_ofs = st_ff.spd_ofs - 16'h0001;
            end
         end
         if (press.data || press.mode_set) begin
            nxt_st.check = CHECK_NONE;
            nxt_st.servo_on = 1'b0;
         end
      end else if (press.mode_set && !editing_setup(st_ff)) begin
         nxt_st.mode = panel_mode_t'(st_ff.mode + 2'h1);
         nxt_st.show_data = 1'b0;
         nxt_st.stored = 1'b0;
      end else if (st_ff.mode == MODE_ALARM) begin
         if (press.up && st_ff.hist_view < 4'(HIST_DEPTH - 1)) begin
            nxt_st.hist_view = st_ff.hist_view + 4'h1;
         end else if (press.down && st_ff.hist_view != HIST_PTR_RST) begin
            nxt_st.hist_view = st_ff.hist_view - 4'h1;
         end
      end else if (st_ff.mode == MODE_SETTINGS) begin
         if (!st_ff.show_data) begin
            if (press.up && st_ff.pnum != PARAM_NUM_MAX) begin
               nxt_st.pnum = st_ff.pnum + 8'h01;
            end else if (press.down && st_ff.pnum != PARAM_SELECTOR) begin
               nxt_st.pnum = st_ff.pnum - 8'h01;
            end
            if (press.data) begin
               nxt_st.show_data = 1'b1;
               nxt_st.stored = 1'b0;
               nxt_st.bit_idx = BIT_IDX_RST;
               nxt_st.edit_word = param_value(st_ff, st_ff.pnum);
            end
         end else if (is_setup(st_ff.pnum)) begin
            if (st_ff.stored) begin
               if (press.data) begin
                  nxt_st.show_data = 1'b0;
               end else if (press.mode_set) begin
                  nxt_st.mode = MODE_MONITOR;
                  nxt_st.show_data = 1'b0;
               end
            end else if (st_ff.sync0[1]) begin
               if (press.left) begin
                  nxt_st.bit_idx = st_ff.bit_idx + 4'h1;
               end else if (press.right) begin
                  nxt_st.bit_idx = st_ff.bit_idx - 4'h1;
               end else if (press.up || press.down) begin
                  nxt_st.edit_word[st_ff.bit_idx] = ~st_ff.edit_word[st_ff.bit_idx];
               end else if (press.mode_set || press.data) begin
                  nxt_st.stored = 1'b1;
               end
            end else begin
               if (press.up) begin
                  nxt_st.bit_idx = st_ff.bit_idx + 4'h1;
               end else if (press.down) begin
                  nxt_st.bit_idx = st_ff.bit_idx - 4'h1;
               end else if (press.mode_set) begin
                  nxt_st.edit_word[st_ff.bit_idx] = ~st_ff.edit_word[st_ff.bit_idx];
               end else if (press.data) begin
                  nxt_st.stored = 1'b1;
               end
            end
            // The nonvolatile copy changes; the active copy waits for power-up.
            if (!st_ff.stored && nxt_st.stored) begin
               nxt_st.nvm_write = 1'b1;
               nxt_st.nvm_addr = st_ff.pnum;
               nxt_st.nvm_data = st_ff.edit_word;
               if (st_ff.pnum == PARAM_SETUP_ONE) begin
                  nxt_st.setup_one_nv = st_ff.edit_word;
               end else begin
                  nxt_st.setup_two_nv = st_ff.edit_word;
               end
            end
         end else begin
            if (press.up) begin
               nxt_st.edit_word = st_ff.edit_word + 16'h0001;
            end else if (press.down) begin
               nxt_st.edit_word = st_ff.edit_word - 16'h0001;
            end else if (press.data) begin
               nxt_st.show_data = 1'b0;
               if (st_ff.pnum == PARAM_JOG_SPEED) begin
                  nxt_st.jog_speed = st_ff.edit_word;
               end else if (st_ff.pnum == PARAM_SELECTOR) begin
                  nxt_st.selector = st_ff.edit_word[7:0];
                  // Unknown codes are dropped so a typo cannot move the motor.
                  case (st_ff.edit_word[7:0])
                     CHK_JOG: nxt_st.check = CHECK_JOG;
                     CHK_AUTO_OFS: begin
                        nxt_st.spd_ofs = speed_cmd_in;
                        nxt_st.trq_ofs = torque_cmd_in;
                     end
                     CHK_HIST_CLR: begin
                        nxt_st.hist_cnt = HIST_PTR_RST;
                        nxt_st.hist_view = HIST_PTR_RST;
                     end
                     CHK_MAN_OFS: nxt_st.check = CHECK_MAN_OFS;
                     CHK_MOTOR: nxt_st.check = CHECK_MOTOR;
                     CHK_TUNE: nxt_st.check = CHECK_TUNE;
                     default: nxt_st.check = CHECK_NONE;
                  endcase
               end
            end
         end
      end
      if (srst_in) begin
         nxt_st = '0;
         nxt_st.mode = MODE_STATUS;
         nxt_st.check = CHECK_NONE;
         nxt_st.jog_speed = JOG_SPEED_RST;
         // Reset stands in for a power cycle: stored words survive and become active.
         // A store without the mark takes the factory words instead.
         // A power-up pattern that happens to equal the mark would be trusted.
         if (st_ff.nv_mark == NV_MARK) begin
            nxt_st.setup_one_nv = st_ff.setup_one_nv;
            nxt_st.setup_two_nv = st_ff.setup_two_nv;
         end else begin
            nxt_st.setup_one_nv = SETUP_ONE_RST;
            nxt_st.setup_two_nv = SETUP_TWO_RST;
         end
         nxt_st.nv_mark = NV_MARK;
         nxt_st.setup_one_act = nxt_st.setup_one_nv;
         nxt_st.setup_two_act = nxt_st.setup_two_nv;
      end
   end

   always_ff @(posedge core_clk_in) begin
      st_ff <= nxt_st;
   end

   always_comb begin
      display_out = '0;
      if (editing_setup(st_ff)) begin
         display_out.bars = st_ff.edit_word;
         display_out.bit_digit = st_ff.bit_idx;
         display_out.bar_mode = 5'h1f;
      end else if (st_ff.mode == MODE_STATUS) begin
         display_out.blank = 5'h00;
         if (drive_status_in.alarm) begin
            display_out.value_lo = st_ff.hist[0];
            display_out.bit_digit = 4'ha;
         end else if (drive_status_in.fwd_prohib) begin
            display_out.value_lo = {6'h00, SYM_FWD_PROHIB};
         end else if (drive_status_in.rev_prohib) begin
            display_out.value_lo = {6'h00, SYM_REV_PROHIB};
         end else if (drive_status_in.running) begin
            display_out.value_lo = {6'h00, SYM_RUN};
         end else begin
            display_out.value_lo = {6'h00, SYM_BASEBLOCK};
         end
      end else if (st_ff.mode == MODE_SETTINGS) begin
         display_out.digits = st_ff.show_data ? st_ff.edit_word : {8'h00, st_ff.pnum};
      end else if (st_ff.mode == MODE_ALARM) begin
         display_out.bit_digit = st_ff.hist_view;
         display_out.value_lo = (st_ff.hist_view < st_ff.hist_cnt) ?
                                st_ff.hist[st_ff.hist_view] : 8'h00;
      end else begin
         display_out.digits = speed_cmd_in - st_ff.spd_ofs;
      end
   end

   assign mode_out = st_ff.mode;
   assign check_out = st_ff.check;
   assign servo_on_out = st_ff.servo_on;
   assign motor_speed_out = (st_ff.check == CHECK_TUNE) ? {1'b0, st_ff.jog_speed[15:1]} :
                            (st_ff.check == CHECK_JOG && st_ff.servo_on) ? st_ff.jog_speed :
                            16'h0000;
   assign setup_one_active_out = st_ff.setup_one_act;
   assign setup_two_active_out = st_ff.setup_two_act;
   assign speed_offset_out = st_ff.spd_ofs;
   assign torque_offset_out = st_ff.trq_ofs;
   assign nvm_write_out = st_ff.nvm_write;
   assign nvm_addr_out = st_ff.nvm_addr;
   assign nvm_data_out = st_ff.nvm_data;
   assign alarm_reset_out = st_ff.alarm_reset;
   assign hist_count_out = st_ff.hist_cnt;
   assign hist_code_out = st_ff.hist[0];
   assign show_data_out = st_ff.show_data;
   assign param_num_out = st_ff.pnum;

endmodule : operator_panel_param_editor

// ===== panel_checker_asserts.sv
`timescale 1ns/1ps
module panel_checker_asserts
   import panel_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire keys_t keys_in,
   input wire panel_mode_t mode_out,
   input wire check_t check_out,
   input wire logic servo_on_out,
   input wire logic [15:0] motor_speed_out,
   input wire logic [15:0] setup_one_active_out,
   input wire logic [15:0] setup_two_active_out,
   input wire logic nvm_write_out,
   input wire logic [3:0] hist_count_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   a_mode_next: assert property (!$past(srst_in) && mode_out != $past(mode_out) |->
      mode_out == panel_mode_t'($past(mode_out) + 2'h1)) else $error("mode skipped a step");
   a_mode_cause: assert property (!$past(srst_in) && mode_out != $past(mode_out) |->
      $past(keys_in.mode_set, 2)) else $error("mode moved without a key");
   a_hist_limit: assert property (hist_count_out <= 4'ha) else $error("history too deep");
   a_hist_step: assert property (!$past(srst_in) && hist_count_out != $past(hist_count_out) |->
      hist_count_out == 4'h0 || hist_count_out == $past(hist_count_out) + 4'h1)
      else $error("history count jumped");
   a_check_mode: assert property (check_out != CHECK_NONE |-> mode_out == MODE_SETTINGS)
      else $error("check outside settings");
   a_speed_idle: assert property (check_out == CHECK_NONE |-> motor_speed_out == 16'h0000)
      else $error("motor driven with no check");
   a_servo_jog: assert property ($rose(servo_on_out) |-> check_out == CHECK_JOG)
      else $error("servo on outside jog");
   a_setup_hold: assert property (!$past(srst_in) |-> $stable(setup_one_active_out) &&
      $stable(setup_two_active_out)) else $error("setup word changed while running");
   a_nvm_pulse: assert property (nvm_write_out |=> !nvm_write_out) else $error("long store");
endmodule : panel_checker_asserts

bind operator_panel_param_editor panel_checker_asserts chk (.core_clk_in, .srst_in, .keys_in,
   .mode_out, .check_out, .servo_on_out, .motor_speed_out, .setup_one_active_out,
   .setup_two_active_out, .nvm_write_out, .hist_count_out);

// ===== keypad_unit_model.sv
`timescale 1ns/1ps
module keypad_unit_model
   import panel_pkg::*;
(
   input wire logic core_clk_in,
   input wire keys_t req_in,
   input wire logic go_in,
   input wire logic [3:0] hold_in,
   output keys_t keys_out,
   output logic busy_out
);
   // A released contact reads low; two idle cycles always follow a press.
   keys_t key_ff = '0;
   logic [4:0] cnt_ff = 5'h00;
   always @(posedge core_clk_in) begin
      if (go_in && cnt_ff == 5'h00) begin
         key_ff <= req_in;
         cnt_ff <= {1'b0, hold_in} + 5'h02;
      end else if (cnt_ff != 5'h00) begin
         cnt_ff <= cnt_ff - 5'h01;
      end
   end
   assign keys_out = (cnt_ff > 5'h02) ? key_ff : '0;
   assign busy_out = (cnt_ff != 5'h00);
endmodule : keypad_unit_model

// ===== test_operator_panel_param_editor.sv
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module test_operator_panel_param_editor;
   import panel_pkg::*;
   localparam logic [7:0] K_MODE = 8'h80, K_DATA = 8'h40, K_UP = 8'h20, K_DOWN = 8'h10;
   localparam logic [7:0] K_LEFT = 8'h08, K_SERVO = 8'h02;
   logic core_clk_in = 1'b0, srst_in = 1'b1, hand_held_in = 1'b1, alarm_raise_in = 1'b0;
   drive_status_t drive_status_in = '0;
   logic [7:0] alarm_code_in = 8'h00;
   logic [15:0] speed_cmd_in = 16'h0000, torque_cmd_in = 16'h0000;
   keys_t keys_in, key_req = '0;
   logic key_go = 1'b0, key_busy;
   logic [3:0] key_hold = 4'h3;
   panel_mode_t mode_out;
   check_t check_out;
   logic servo_on_out, nvm_write_out, alarm_reset_out, show_data_out;
   logic [15:0] motor_speed_out, setup_one_active_out, setup_two_active_out;
   logic [15:0] speed_offset_out, torque_offset_out, nvm_data_out, nvm_data_seen;
   logic [7:0] nvm_addr_out, hist_code_out, param_num_out, nvm_addr_seen;
   logic [3:0] hist_count_out;
   display_t display_out;
   logic [31:0] seed = 32'h0032b20d;
   int err_total = 0, num_checks = 0, cycles = 0, nvm_seen = 0;

   operator_panel_param_editor uut (.core_clk_in, .srst_in, .hand_held_in, .keys_in,
      .drive_status_in, .alarm_raise_in, .alarm_code_in, .speed_cmd_in, .torque_cmd_in,
      .mode_out, .check_out, .servo_on_out, .motor_speed_out, .setup_one_active_out,
      .setup_two_active_out, .speed_offset_out, .torque_offset_out, .nvm_write_out,
      .nvm_addr_out, .nvm_data_out, .alarm_reset_out, .hist_count_out, .hist_code_out,
      .show_data_out, .param_num_out, .display_out);
   keypad_unit_model pad (.core_clk_in, .req_in(key_req), .go_in(key_go), .hold_in(key_hold),
      .keys_out(keys_in), .busy_out(key_busy));

   initial begin
      forever #5 core_clk_in = ~core_clk_in;
   end
   // Sampled on the falling edge so the one-cycle store pulse is seen without a race.
   always @(negedge core_clk_in) begin
      if (nvm_write_out === 1'b1) begin
         nvm_seen++;
         nvm_addr_seen = nvm_addr_out;
         nvm_data_seen = nvm_data_out;
      end
   end
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 8000) begin
         err_total++;
         stop_test;
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check_val
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic do_reset;
      srst_in <= 1'b1;
      repeat (5) @(posedge core_clk_in);
      srst_in <= 1'b0;
      @(posedge core_clk_in);
   endtask : do_reset
   // Hold time is drawn at random so slow and prompt operators both occur.
   task automatic press(input logic [7:0] k);
      key_req <= keys_t'(k);
      key_hold <= 4'h3 + {2'h0, seed[1:0]};
      key_go <= 1'b1;
      @(posedge core_clk_in);
      key_go <= 1'b0;
      seed = xs(seed);
      do @(posedge core_clk_in); while (key_busy === 1'b1);
      repeat (2) @(posedge core_clk_in);
   endtask : press
   task automatic select_check(input int code);
      press(K_MODE);
      press(K_DATA);
      repeat (code) press(K_UP);
      press(K_DATA);
   endtask : select_check

   initial begin
      logic [15:0] w, spd, trq;
      logic [3:0] n;
      logic [3:0] sv [4];
      logic [1:0] sym [4];
      sv = '{4'h0, 4'h1, 4'h4, 4'h2};
      sym = '{SYM_BASEBLOCK, SYM_RUN, SYM_FWD_PROHIB, SYM_REV_PROHIB};
      do_reset;
      for (int i = 0; i < 4; i++) begin
         drive_status_in <= drive_status_t'(sv[i]);
         repeat (2) @(posedge core_clk_in);
         `CHK(display_out.value_lo[1:0], sym[i]);
      end
      for (int i = 1; i <= 4; i++) begin
         press(K_MODE);
         `CHK(mode_out, i % 4);
      end
      w = SETUP_ONE_RST;
      n = seed[3:0];
      press(K_MODE);
      press(K_UP);
      `CHK(param_num_out, PARAM_SETUP_ONE);
      press(K_DATA);
      `CHK(show_data_out, 1'b1);
      `CHK(display_out.bars, w);
      repeat (n) press(K_LEFT);
      `CHK(display_out.bit_digit, n);
      press(K_UP);
      w[n] = ~w[n];
      `CHK(display_out.bars, w);
      press(K_DATA);
      `CHK({nvm_seen, nvm_addr_seen, nvm_data_seen}, {32'd1, PARAM_SETUP_ONE, w});
      press(K_DATA);
      `CHK(show_data_out, 1'b0);
      press(K_MODE);
      `CHK(mode_out, MODE_MONITOR);
      `CHK(setup_one_active_out, SETUP_ONE_RST);
      do_reset;
      `CHK({setup_one_active_out, setup_two_active_out}, {w, SETUP_TWO_RST});
      hand_held_in <= 1'b0;
      press(K_MODE);
      press(K_UP);
      press(K_DATA);
      press(K_UP);
      `CHK(display_out.bit_digit, 4'h1);
      press(K_DOWN);
      `CHK(display_out.bit_digit, 4'h0);
      press(K_MODE);
      w[0] = ~w[0];
      `CHK({mode_out, display_out.bars, 8'(nvm_seen)}, {MODE_SETTINGS, w, 8'd1});
      press(K_DATA);
      `CHK({nvm_seen, nvm_data_seen}, {32'd2, w});
      hand_held_in <= 1'b1;
      for (int c = 0; c < 7; c++) begin
         do_reset;
         spd = seed[15:0];
         trq = seed[31:16];
         speed_cmd_in <= spd;
         torque_cmd_in <= trq;
         if (c == 2) begin
            for (int i = 1; i <= 11; i++) begin
               alarm_code_in <= 8'(i);
               alarm_raise_in <= 1'b1;
               repeat (3) @(posedge core_clk_in);
               alarm_raise_in <= 1'b0;
               repeat (3) @(posedge core_clk_in);
            end
            `CHK({hist_count_out, hist_code_out}, {4'ha, 8'h0b});
            drive_status_in <= 4'h8;
            repeat (2) @(posedge core_clk_in);
            `CHK({display_out.bit_digit, display_out.value_lo}, {4'ha, 8'h0b});
         end
         select_check(c);
         case (c)
            0: begin
               `CHK(check_out, CHECK_JOG);
               press(K_SERVO);
               `CHK({servo_on_out, motor_speed_out}, {1'b1, JOG_SPEED_RST});
               press(K_SERVO);
               `CHK(servo_on_out, 1'b0);
            end
            1: `CHK({speed_offset_out, torque_offset_out}, {spd, trq});
            2: `CHK({hist_count_out, check_out}, {4'h0, CHECK_NONE});
            3: begin
               `CHK(check_out, CHECK_MAN_OFS);
               press(K_UP);
               `CHK({speed_offset_out, torque_offset_out}, {16'h0001, 16'h0000});
            end
            4: `CHK(check_out, CHECK_MOTOR);
            5: `CHK({check_out, motor_speed_out}, {CHECK_TUNE, JOG_SPEED_RST >> 1});
            default: `CHK({check_out, mode_out}, {CHECK_NONE, MODE_SETTINGS});
         endcase
      end
      stop_test;
   end
endmodule : test_operator_panel_param_editor
